// ===== design/vie_map.svh
`ifndef VIE_MAP_SVH
`define VIE_MAP_SVH
// Register indices on the plain register port
`define VIE_ADDR_VECTOR   4'h0
`define VIE_ADDR_CONFIG   4'h1
`define VIE_ADDR_STATUS   4'h2
`define VIE_ADDR_CLEAR    4'h3
`define VIE_ADDR_ENABLE   4'h4
`define VIE_ADDR_PENDING  4'h5
// Config register fields
`define VIE_CFG_SELECT_BIT 0
// Reset values
`define VIE_VECTOR_RESET  8'h00
`define VIE_CONFIG_RESET  8'h00
// Event status bits
`define VIE_EV_RETIRE     0
`define VIE_EV_OVERRUN    1
// Fixed source vectors (lowest priority first)
`define VIE_VEC_OUT_EP1   8'h12
`define VIE_VEC_OUT_EP2   8'h14
`define VIE_VEC_OUT_EP3   8'h16
`define VIE_VEC_IN_EP1    8'h22
`define VIE_VEC_IN_EP2    8'h24
`define VIE_VEC_IN_EP3    8'h26
`define VIE_VEC_SETUP_OVW 8'h30
`define VIE_VEC_SETUP_RX  8'h32
`define VIE_VEC_PWR_ON    8'h34
`define VIE_VEC_PWR_OFF   8'h36
`define VIE_VEC_RESUME    8'h38
`define VIE_VEC_SUSPEND   8'h3a
`define VIE_VEC_BUS_RST   8'h3c
`define VIE_VEC_TX_EMPTY  8'h40
`define VIE_VEC_RX_FULL   8'h42
`define VIE_VEC_IN_EP0    8'h44
`define VIE_VEC_OUT_EP0   8'h46
`endif

// ===== design/vie_pkg.sv
package vie_pkg;
  // Number of used sources
  localparam int NSRC = 17;
  // Source request bundle, one bit per used vector
  typedef struct packed {
    logic out_ep0;
    logic in_ep0;
    logic receiver_full_event;
    logic transmitter_empty_event;
    logic bus_reset_event;
    logic suspend_event;
    logic resume_event;
    logic power_off_event;
    logic power_on_event;
    logic setup_received_event;
    logic setup_overwrite_event;
    logic in_ep3;
    logic in_ep2;
    logic in_ep1;
    logic out_ep3;
    logic out_ep2;
    logic out_ep1;
  } vie_src_t;
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } vie_bus_t;
endpackage

// ===== design/vie_encoder.sv
`timescale 1ns/1ps
`include "vie_map.svh"
// Behaviour
// - Vector register names source behind internal trap
// - Any vector write retires, loads next pending
// - Vector bit 0 always reads zero
// - No pending request presents vector zero
// - Group in bits 7-4, index 3-1
// - Same group: oldest request served first
// - Higher group number wins
// - Endpoint events use fixed vectors
// - Bus and serial events use fixed vectors
// - Eight-bit vector covers 128 sources
// - Fixed group priority; on equal age 46h highest, 12h lowest
// - OR of eight port inputs forms request
// - Port inputs active low, level request
// - Port request also drives wake-up output
// - Select bit picks dedicated pin or port
// - Pending sources OR into active-low line
module vie_encoder #(
  parameter int AGE_W = 8  // Width of arrival stamps
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RST,
  input  wire vie_pkg::vie_src_t SRC_EVENTS,
  input  wire vie_pkg::vie_bus_t REG_BUS,
  output logic [7:0]            REG_RDATA,
  input  wire logic [7:0]       GENERAL_PORT_INPUTS_N,
  input  wire logic             DEDICATED_IRQ_PIN_N,
  output logic                  INTERNAL_IRQ_LINE_N,
  output logic                  PORT_IRQ_LINE_N,
  output logic                  PORT_WAKE_REQ,
  output logic                  STATUS_IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Source table
  ////////////////////////////////////////////////////////////////////////
  localparam int N = vie_pkg::NSRC;
  // Vector per source, index order matches the struct (bit 0 = lowest)
  localparam logic [7:0] VEC [N] = '{
    `VIE_VEC_OUT_EP1, `VIE_VEC_OUT_EP2, `VIE_VEC_OUT_EP3,
    `VIE_VEC_IN_EP1, `VIE_VEC_IN_EP2, `VIE_VEC_IN_EP3,
    `VIE_VEC_SETUP_OVW, `VIE_VEC_SETUP_RX, `VIE_VEC_PWR_ON,
    `VIE_VEC_PWR_OFF, `VIE_VEC_RESUME, `VIE_VEC_SUSPEND,
    `VIE_VEC_BUS_RST, `VIE_VEC_TX_EMPTY, `VIE_VEC_RX_FULL,
    `VIE_VEC_IN_EP0, `VIE_VEC_OUT_EP0};

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////
  logic [N-1:0]     src_raw;        // Flattened request pulses
  logic [N-1:0]     pend_r;         // Pending flags
  logic [AGE_W-1:0] stamp_r [N];    // Arrival stamp per source
  logic [AGE_W-1:0] clock_r;        // Free-running arrival counter
  logic [7:0]       vec_r;          // Presented vector
  logic [7:0]       vec_nxt;        // Next vector from the encoder
  int               sel_nxt;        // Index of chosen source
  logic             sel_valid;      // A source is chosen
  logic             cur_valid_r;    // Vector currently presented
  int               cur_idx_r;      // Index of presented source
  logic [7:0]       config_r;       // Select bit lives here
  logic [1:0]       stat_r;         // Sticky event status
  logic [1:0]       enable_r;       // Event interrupt enables
  logic [7:0]       port_sync1_r;   // Port input first stage
  logic [7:0]       port_sync2_r;   // Port input second stage
  logic [1:0]       pin_sync_r;     // Dedicated pin synchroniser
  logic             vec_write;      // Retire strobe
  logic [N-1:0]     retire_mask;    // Pending bit to drop
  logic [N-1:0]     overrun;        // Event on already pending source

  assign src_raw   = SRC_EVENTS;
  assign vec_write = REG_BUS.wr && (REG_BUS.addr == `VIE_ADDR_VECTOR);

  ////////////////////////////////////////////////////////////////////////
  // Pending flags and arrival stamps
  ////////////////////////////////////////////////////////////////////////
  // Retire only the presented source; a new event in the same cycle wins
  always_comb begin
    retire_mask = '0;
    if (vec_write && cur_valid_r) begin
      retire_mask[cur_idx_r] = 1'b1;
    end
  end

  assign overrun = src_raw & pend_r & ~retire_mask;

  // Arrival counter advances each cycle; wrap limits age ordering range
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      clock_r <= '0;
    end else begin
      clock_r <= clock_r + 1'b1;
    end
  end

  generate
    for (genvar g = 0; g < N; g++) begin : g_src
      // Held until the presented vector is retired by a write
      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          pend_r[g]  <= 1'b0;
          stamp_r[g] <= '0;
        end else if (src_raw[g]) begin
          pend_r[g] <= 1'b1;
          if (!pend_r[g] || retire_mask[g]) begin
            stamp_r[g] <= clock_r;
          end
        end else if (retire_mask[g]) begin
          pend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Priority encoder
  ////////////////////////////////////////////////////////////////////////
  // Highest group wins; within a group, the oldest stamp wins
  // The source being retired is left out, so a retire loads the next one
  // Equal stamps go to the higher index, keeping out_ep0 above in_ep0
  always_comb begin
    logic [AGE_W-1:0] best_age;
    logic [AGE_W-1:0] age;
    sel_nxt   = 0;
    sel_valid = 1'b0;
    best_age  = '0;
    age       = '0;
    for (int i = 0; i < N; i++) begin
      age = clock_r - stamp_r[i];
      if (pend_r[i] && !retire_mask[i]) begin
        if (!sel_valid || VEC[i][7:4] > VEC[sel_nxt][7:4]) begin
          sel_nxt   = i;
          sel_valid = 1'b1;
          best_age  = age;
        end else if (VEC[i][7:4] == VEC[sel_nxt][7:4] && age >= best_age) begin
          sel_nxt  = i;
          best_age = age;
        end
      end
    end
    // Bit 0 forced low; empty gives zero
    vec_nxt = sel_valid ? {VEC[sel_nxt][7:1], 1'b0} : `VIE_VECTOR_RESET;
  end

  ////////////////////////////////////////////////////////////////////////
  // Presented vector
  ////////////////////////////////////////////////////////////////////////
  // Presented vector held steady while pending; reloads on retire or idle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      vec_r       <= `VIE_VECTOR_RESET;
      cur_valid_r <= 1'b0;
      cur_idx_r   <= 0;
    end else if (vec_write || !cur_valid_r) begin
      vec_r       <= vec_nxt;
      cur_valid_r <= sel_valid;
      cur_idx_r   <= sel_nxt;
    end
  end

  // Active-low level while anything is pending
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      INTERNAL_IRQ_LINE_N <= 1'b1;
    end else begin
      INTERNAL_IRQ_LINE_N <= ~(|(pend_r & ~retire_mask));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port interrupt path
  ////////////////////////////////////////////////////////////////////////
  // Pins are asynchronous: two stages before any use
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      port_sync1_r <= 8'hff;
      port_sync2_r <= 8'hff;
      pin_sync_r   <= 2'h3;
    end else begin
      port_sync1_r <= GENERAL_PORT_INPUTS_N;
      port_sync2_r <= port_sync1_r;
      pin_sync_r   <= {pin_sync_r[0], DEDICATED_IRQ_PIN_N};
    end
  end

  // Any low input raises the level request; the select picks the source
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PORT_IRQ_LINE_N <= 1'b1;
      PORT_WAKE_REQ   <= 1'b0;
    end else begin
      PORT_WAKE_REQ   <= |(~port_sync2_r);
      PORT_IRQ_LINE_N <= config_r[`VIE_CFG_SELECT_BIT] ? ~(|(~port_sync2_r))
                                                       : pin_sync_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  ////////////////////////////////////////////////////////////////////////
  // Config and enable registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      config_r <= `VIE_CONFIG_RESET;
      enable_r <= '0;
    end else if (REG_BUS.wr) begin
      if (REG_BUS.addr == `VIE_ADDR_CONFIG) begin
        config_r <= {7'h00, REG_BUS.wdata[`VIE_CFG_SELECT_BIT]};
      end else if (REG_BUS.addr == `VIE_ADDR_ENABLE) begin
        enable_r <= REG_BUS.wdata[1:0];
      end
    end
  end

  // Sticky status: set beats a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    logic [1:0] clr;
    logic [1:0] set;
    clr = (REG_BUS.wr && REG_BUS.addr == `VIE_ADDR_CLEAR) ? REG_BUS.wdata[1:0] : 2'h0;
    set = 2'h0;
    set[`VIE_EV_RETIRE]  = vec_write && cur_valid_r;
    set[`VIE_EV_OVERRUN] = |overrun;
    if (RST) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~clr) | set;
    end
  end

  assign STATUS_IRQ = |(stat_r & enable_r);

  ////////////////////////////////////////////////////////////////////////
  // Register reads
  ////////////////////////////////////////////////////////////////////////
  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_BUS.rd) begin
      if (REG_BUS.addr == `VIE_ADDR_VECTOR) begin
        REG_RDATA <= vec_r;
      end else if (REG_BUS.addr == `VIE_ADDR_CONFIG) begin
        REG_RDATA <= config_r;
      end else if (REG_BUS.addr == `VIE_ADDR_STATUS) begin
        REG_RDATA <= {6'h00, stat_r};
      end else if (REG_BUS.addr == `VIE_ADDR_ENABLE) begin
        REG_RDATA <= {6'h00, enable_r};
      end else if (REG_BUS.addr == `VIE_ADDR_PENDING) begin
        REG_RDATA <= {7'h00, ~INTERNAL_IRQ_LINE_N};
      end else begin
        REG_RDATA <= 8'h00;
      end
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule

// ===== test/vie_encoder_assertions.sv
`timescale 1ns/1ps
`include "vie_map.svh"
// Port-level watch of the vector encoder
module vie_encoder_checker #(
  parameter int AGE_W = 8  // Same stamp width as the design
) (
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire vie_pkg::vie_src_t SRC_EVENTS,
  input wire vie_pkg::vie_bus_t REG_BUS,
  input wire logic [7:0]        REG_RDATA,
  input wire logic [7:0]        GENERAL_PORT_INPUTS_N,
  input wire logic              DEDICATED_IRQ_PIN_N,
  input wire logic              INTERNAL_IRQ_LINE_N,
  input wire logic              PORT_IRQ_LINE_N,
  input wire logic              PORT_WAKE_REQ,
  input wire logic              STATUS_IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [1:0] age_r;  // Edges since reset, stops at 3
  // Sync pipe still holds reset values until it has filled
  always_ff @(posedge CORE_CLK) begin
    if (RST) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  sequence vec_rd;  // Read of the vector
    REG_BUS.rd && REG_BUS.addr == `VIE_ADDR_VECTOR;
  endsequence
  ////////////////////////////////////////////////////////////
  bit_zero_a: assert property (vec_rd |=> !REG_RDATA[0]) else $error("vector bit 0 set");
  idle_rdata_a: assert property (!REG_BUS.rd |=> REG_RDATA == 8'h00) else $error("data outside read");
  idle_vector_a: assert property (vec_rd ##0 INTERNAL_IRQ_LINE_N |=> REG_RDATA == 8'h00)
    else $error("vector not zero while idle");
  vector_legal_a: assert property (vec_rd ##0 !INTERNAL_IRQ_LINE_N |=> REG_RDATA inside
    {[8'h12:8'h16], [8'h22:8'h26], [8'h30:8'h3c], [8'h40:8'h46]}) else $error("reserved vector");
  irq_assert_a: assert property (|SRC_EVENTS |-> ##2 !INTERNAL_IRQ_LINE_N) else $error("line not low");
  irq_release_a: assert property ($rose(INTERNAL_IRQ_LINE_N) |->
    $past(REG_BUS.wr && REG_BUS.addr == `VIE_ADDR_VECTOR)) else $error("line released without retire");
  wake_follow_a: assert property (age_r == 2'h3 |-> PORT_WAKE_REQ == $past(!(&GENERAL_PORT_INPUTS_N), 3))
    else $error("wake request wrong");
  reset_state_a: assert property (disable iff (1'b0) RST |=> INTERNAL_IRQ_LINE_N && PORT_IRQ_LINE_N
    && !PORT_WAKE_REQ && REG_RDATA == 8'h00) else $error("reset state wrong");
endmodule
bind vie_encoder vie_encoder_checker #(.AGE_W(AGE_W)) i_vie_encoder_checker (.CORE_CLK, .RST, .SRC_EVENTS,
  .REG_BUS, .REG_RDATA, .GENERAL_PORT_INPUTS_N, .DEDICATED_IRQ_PIN_N, .INTERNAL_IRQ_LINE_N,
  .PORT_IRQ_LINE_N, .PORT_WAKE_REQ, .STATUS_IRQ);

// ===== test/vie_core_model.sv
`timescale 1ns/1ps
`include "vie_map.svh"
// Core and firmware: owns the register port, serves the vector
module vie_core_model (
  input  wire logic         CORE_CLK,
  output vie_pkg::vie_bus_t REG_BUS,
  input  wire logic [7:0]   REG_RDATA,
  input  wire logic         INTERNAL_IRQ_LINE_N
);
  initial REG_BUS = '0;
  // One-cycle strobe; the extra edge keeps calls from colliding
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CORE_CLK);
    REG_BUS <= '0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    REG_BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CORE_CLK);
    REG_BUS <= '0;
    #1 d = REG_RDATA;
  endtask
  // Level trap: poll the line, read the vector, retire with any data
  task automatic service(output logic [7:0] v, output bit ok);
    ok = 1'b0;
    v = 8'h00;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge CORE_CLK);
      #1 ok = (INTERNAL_IRQ_LINE_N === 1'b0);
    end
    if (ok) begin
      rd(`VIE_ADDR_VECTOR, v);
      wr(`VIE_ADDR_VECTOR, 8'($urandom));
    end
  endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "vie_map.svh"
// Self-checking bench for the vector encoder
module tb_top;
  logic              clk = 1'b0;     // 25 MHz
  logic              rst = 1'b1;     // Held 3 cycles
  vie_pkg::vie_src_t src = '0;       // Source pulses
  vie_pkg::vie_bus_t bus;            // Driven by the core model
  logic [7:0]        rdata;
  logic [7:0]        pins_n = 8'hff;  // Port inputs, idle high
  logic              pin_n = 1'b1;   // Dedicated pin
  logic              irq_n, port_n, wake, st_irq;
  logic [7:0]        v;
  bit                ok;
  int                err_count = 0;
  int                num_checks = 0;
  int                ord [$];
  int                j, t;
  always #20 clk = ~clk;
  vie_encoder #(.AGE_W(8)) i_vie_encoder (.CORE_CLK(clk), .RST(rst), .SRC_EVENTS(src), .REG_BUS(bus),
    .REG_RDATA(rdata), .GENERAL_PORT_INPUTS_N(pins_n), .DEDICATED_IRQ_PIN_N(pin_n), .INTERNAL_IRQ_LINE_N(irq_n),
    .PORT_IRQ_LINE_N(port_n), .PORT_WAKE_REQ(wake), .STATUS_IRQ(st_irq));
  vie_core_model i_vie_core_model (.CORE_CLK(clk), .REG_BUS(bus), .REG_RDATA(rdata), .INTERNAL_IRQ_LINE_N(irq_n));
  ////////////////////////////////////////////////////////////
  // Fixed vector of source bit i, groups of 3, 3, 7, 4
  function automatic logic [7:0] vec_of(input int i);
    if (i < 3) return 8'h12 + 8'(2 * i);
    if (i < 6) return 8'h22 + 8'(2 * (i - 3));
    if (i < 13) return 8'h30 + 8'(2 * (i - 6));
    return 8'h40 + 8'(2 * (i - 13));
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A trap that never comes ends the run
  task automatic serve(input logic [7:0] exp);
    i_vie_core_model.service(v, ok);
    if (!ok) begin
      err_count++;
      results();
    end
    chk(v, exp);
  endtask
  task automatic fire(input logic [16:0] s);
    @(posedge clk);
    src <= vie_pkg::vie_src_t'(s);
    @(posedge clk);
    src <= '0;
  endtask
  // Port path has a fixed three-edge latency
  task automatic port(input logic [7:0] p, input logic d, input logic [1:0] exp);
    @(posedge clk);
    pins_n <= p;
    pin_n <= d;
    repeat (3) @(posedge clk);
    #1 chk({6'h00, port_n, wake}, {6'h00, exp});
  endtask
  initial begin
    void'($urandom(9623));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    i_vie_core_model.rd(`VIE_ADDR_VECTOR, v);
    chk(v, 8'h00);
    i_vie_core_model.rd(4'hf, v);
    chk(v, 8'h00);
    $display("test reset done");
    // Everything at once: groups high to low, index high to low within
    fire('1);
    for (int g = 4; g > 0; g--)
      for (int i = vie_pkg::NSRC - 1; i >= 0; i--)
        if (vec_of(i) >> 4 == g) serve(vec_of(i));
    i_vie_core_model.rd(`VIE_ADDR_VECTOR, v);
    chk({v[7:1], irq_n}, 8'h01);
    $display("test priority done");
    // Group 3 in a random order of arrival, one per cycle
    ord = {6, 7, 8, 9, 10, 11, 12};
    for (int k = 6; k > 0; k--) begin
      j = $urandom % (k + 1);
      t = ord[k];
      ord[k] = ord[j];
      ord[j] = t;
    end
    foreach (ord[k]) begin
      @(posedge clk);
      src <= vie_pkg::vie_src_t'(17'h1 << ord[k]);
    end
    @(posedge clk);
    src <= '0;
    foreach (ord[k]) serve(vec_of(ord[k]));
    $display("test arrival done");
    // Overrun raises, masks and clears the status interrupt
    i_vie_core_model.wr(`VIE_ADDR_CLEAR, 8'hff);
    i_vie_core_model.wr(`VIE_ADDR_ENABLE, 8'h02);
    fire(17'h1);
    fire(17'h1);
    i_vie_core_model.rd(`VIE_ADDR_STATUS, v);
    chk({v[7:1], st_irq}, 8'h03);
    i_vie_core_model.rd(`VIE_ADDR_PENDING, v);
    chk(v, 8'h01);
    i_vie_core_model.wr(`VIE_ADDR_ENABLE, 8'h00);
    #1 chk({7'h00, st_irq}, 8'h00);
    i_vie_core_model.wr(`VIE_ADDR_ENABLE, 8'h02);
    i_vie_core_model.wr(`VIE_ADDR_CLEAR, 8'h02);
    #1 chk({7'h00, st_irq}, 8'h00);
    serve(8'h12);
    i_vie_core_model.rd(`VIE_ADDR_STATUS, v);
    chk(v, 8'h01);
    $display("test status done");
    // Port source select and wake path
    i_vie_core_model.wr(`VIE_ADDR_CONFIG, 8'h00);
    port(8'h00, 1'b1, 2'b11);
    port(8'hff, 1'b0, 2'b00);
    i_vie_core_model.wr(`VIE_ADDR_CONFIG, 8'h01);
    port(8'hff, 1'b0, 2'b10);
    port(~(8'h01 << ($urandom % 8)) & 8'($urandom), 1'b1, 2'b01);
    $display("test port done");
    results();
  end
endmodule
